// >>> dv/nfc_flash_model.sv
// flash device model
`timescale 1ns/100ps
module nfc_flash_model
    import nfc_pkg::*;
#(
    parameter int AW = 20,
    parameter int PROG_STEPS = 20
)
(
    // flash pins
    input wire logic [AW-1:0] fl_addr,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic fl_reset_n,
    input wire logic boot_guard_boost_pin,
    input wire logic [15:0] fl_dq_out,
    output logic [15:0] fl_dq_in
);
    logic [15:0] mem [1024];
    logic [15:0] otpm [256];
    logic [15:0] noise = 16'h5A5A;
    logic [AW-1:0] la;
    logic [AW-1:0] pa;
    logic [15:0] pd;
    int n = 0;
    int left = 0;
    bit pgm, query, otp, lock, exitp, busy, susp, po;
    realtime t_fall = 0;
    realtime t_up = 0;
    wire boot = (la[AW-1:13] == '0) || (&la[AW-1:13]);
    wire drive = !fl_ce_n && !fl_oe_n && fl_reset_n && ($realtime - t_up >= WAKE_NS);
    initial foreach (mem[i]) mem[i] = 16'hFFFF;
    initial foreach (otpm[i]) otpm[i] = 16'hFFFF;
    always #10 noise = ~noise;
    // released bus toggles; any bank reads while busy
    assign fl_dq_in = !drive ? noise : query ? {8'h00, fl_addr[7:0] ^ 8'h3C}
        : (otp && fl_addr < 256) ? otpm[fl_addr[7:0]] : mem[fl_addr[9:0]];
    ////////////////////////////////////////
    always @(negedge fl_we_n or negedge fl_ce_n)
        if (!fl_we_n && !fl_ce_n)
        begin
            la = fl_addr;
            t_fall = $realtime;
        end
    always @(posedge fl_we_n or posedge fl_ce_n)
        if (fl_oe_n && fl_reset_n && (fl_we_n ^ fl_ce_n) && $realtime - t_fall >= 5)
        begin
            if (fl_dq_out == CMD_RESET && !busy)
                {query, pgm, n} = '0;
            else if (fl_dq_out == CMD_PSUSPEND && busy)
                {busy, susp} = 2'b01;
            else if (fl_dq_out == CMD_PRESUME && susp)
                {busy, susp} = 2'b10;
            else if (busy)
                n = 0;
            else if (pgm)
            begin
                {pgm, po, pa, pd, left} = {1'b0, otp && la < 256, la, fl_dq_out, PROG_STEPS};
                busy = po ? !lock : boot_guard_boost_pin || !boot;
            end
            else if (otp && fl_dq_out == CMD_OTP_EXIT1)
                exitp = 1;
            else if (exitp)
                {exitp, otp, n} = {1'b0, fl_dq_out != CMD_OTP_EXIT2, 32'd0};
            else if (fl_dq_out == CMD_QUERY && la == AW'(CMD_QUERY_ADDR))
                query = 1;
            else if (n < 2)
                n = (fl_dq_out == (n == 0 ? CMD_UNLOCK1_DATA : CMD_UNLOCK2_DATA)) ? n + 1 : 0;
            else
            begin
                n = 0;
                pgm = fl_dq_out == CMD_PROGRAM && !susp;
                lock = lock || (otp && !susp && fl_dq_out == CMD_OTP_LOCK);
                otp = otp || fl_dq_out == CMD_OTP_ENTER;
            end
        end
    // program in 100 ns steps
    always #100
        if (busy)
        begin
            left = left - 1;
            busy = left != 0;
            if (!busy && po)
                otpm[pa[7:0]] = pd;
            if (!busy && !po)
                mem[pa[9:0]] = pd;
        end
    always @(negedge fl_reset_n)
        {busy, susp, pgm, query, otp, exitp, n} = '0;
    always @(posedge fl_reset_n)
        t_up = $realtime;
endmodule : nfc_flash_model

// >>> dv/nfc_host_checker.sv
// pin timing checker
`timescale 1ns/100ps
module nfc_host_checker
    import nfc_pkg::*;
#(
    parameter int AW = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // flash pins
    input wire logic [AW-1:0] fl_addr,
    input wire logic fl_ce_n,
    input wire logic fl_oe_n,
    input wire logic fl_we_n,
    input wire logic fl_reset_n,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_dq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    int low_cnt;
    int wake_cnt;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            low_cnt <= RESET_HOLD_CYC;
        else
            low_cnt <= fl_reset_n ? 0 : low_cnt + 1;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            wake_cnt <= WAKE_CYC;
        else
            wake_cnt <= !fl_reset_n ? 0 : wake_cnt + int'(wake_cnt < WAKE_CYC);
    ////////////////////////////////////////
    write_combo_a: assert property (!fl_we_n |-> !fl_ce_n && fl_oe_n)
        else $error("bad write combo");
    no_fight_a: assert property (fl_dq_oe |-> fl_oe_n)
        else $error("dq fight");
    strobe_width_a: assert property ($fell(fl_we_n) |=> !fl_we_n)
        else $error("short strobe");
    addr_order_a: assert property ($fell(fl_we_n) |-> !$past(fl_ce_n) && fl_dq_oe)
        else $error("ce late");
    hold_pins_a: assert property (!fl_we_n |=> $stable(fl_addr) && $stable(fl_dq_out))
        else $error("pins moved");
    data_late_a: assert property ($rose(fl_we_n) |-> !fl_ce_n && fl_dq_oe)
        else $error("ce rose early");
    hold_len_a: assert property ($rose(fl_reset_n) |-> low_cnt >= RESET_HOLD_CYC)
        else $error("short reset");
    wake_wait_a: assert property (!fl_oe_n |-> wake_cnt >= WAKE_CYC)
        else $error("early read");
    reset_quiet_a: assert property (!fl_reset_n |-> fl_ce_n && !fl_dq_oe)
        else $error("bus in reset");
endmodule : nfc_host_checker
bind nfc_host nfc_host_checker #(.AW(AW)) i_chk (.*);

// >>> dv/nfc_host_tb_top.sv
// testbench for the flash host
`timescale 1ns/100ps
module nfc_host_tb_top
    import nfc_pkg::*;
();
    logic clk = 0;
    logic rst_n = 0;
    logic ce = 1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 0;
    logic reg_rd = 0;
    logic [31:0] reg_rdata;
    logic [19:0] fl_addr;
    logic fl_ce_n, fl_oe_n, fl_we_n, fl_reset_n, boot_guard_boost_pin, fl_dq_oe;
    logic [15:0] fl_dq_out;
    logic [15:0] fl_dq_in;
    logic g = 0;
    int num_errors = 0;
    int cmp_count = 0;
    always #10 clk = ~clk;
    nfc_host #(.AW(20)) i_dut (.*);
    nfc_flash_model #(.AW(20)) i_flash (.*);
    ////////////////////////////////////////
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string w);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge clk);
        reg_wr <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic op(input nfc_op_t o, input logic [19:0] a, input logic [15:0] d);
        logic [31:0] s;
        wr(REG_ADDR, {12'h0, a});
        wr(REG_DATA, {16'h0, d});
        wr(REG_CTRL, {25'h0, 1'b0, g, 1'b1, o});
        s = 1;
        for (int i = 0; i < 300 && s[0] !== 1'b0; i++)
            rd(REG_STATUS, s);
        cmp({31'h0, s[0]}, 32'h0, "idle");
    endtask : op
    task automatic st(input logic [7:0] m, input logic [7:0] e, input string w);
        logic [31:0] s;
        rd(REG_STATUS, s);
        cmp(s & {24'h0, m}, {24'h0, e}, w);
    endtask : st
    task automatic rdchk(input logic [19:0] a, input logic [15:0] e, input string w);
        logic [31:0] s;
        op(NFC_OP_READ, a, 16'h0);
        rd(REG_RDATA, s);
        cmp({16'h0, s[15:0]}, {16'h0, e}, w);
    endtask : rdchk
    ////////////////////////////////////////
    task automatic t_basic();
        logic [31:0] s;
        rd(REG_CTRL, s);
        cmp(s, {30'h0, CTRL_RESET_VALUE}, "ctrl");
        rd(4'hF, s);
        cmp(s, 32'h0, "unmapped");
        cmp({31'h0, fl_reset_n}, 32'h1, "fl rst");
        rdchk(20'h10010, 16'hFFFF, "pwrup");
        op(NFC_OP_PROGRAM, 20'h10001, 16'h5A3C);
        op(NFC_OP_RESET, 20'h0, 16'h0);
        rdchk(20'hF0003, 16'hFFFF, "rww");
        repeat (140) @(posedge clk);
        rdchk(20'h10001, 16'h5A3C, "prog");
        $display("test basic done");
    endtask : t_basic
    task automatic t_suspend();
        op(NFC_OP_PROGRAM, 20'h10005, 16'h1234);
        op(NFC_OP_SUSPEND, 20'h0, 16'h0);
        st(8'h18, 8'h10, "susp");
        op(NFC_OP_PROGRAM, 20'h10006, 16'h0000);
        st(8'h08, 8'h08, "prog ref");
        op(NFC_OP_OTP_LOCK, 20'h0, 16'h0);
        st(8'h48, 8'h08, "lock ref");
        rdchk(20'h10005, 16'hFFFF, "susp rd");
        op(NFC_OP_RESUME, 20'h0, 16'h0);
        st(8'h18, 8'h00, "resume");
        repeat (140) @(posedge clk);
        rdchk(20'h10005, 16'h1234, "res word");
        op(NFC_OP_RESUME, 20'h0, 16'h0);
        st(8'h08, 8'h08, "res ref");
        $display("test suspend done");
    endtask : t_suspend
    task automatic t_query();
        op(NFC_OP_QUERY, 20'h0, 16'h0);
        st(8'h80, 8'h80, "query");
        rdchk(20'h00010, 16'h002C, "q byte");
        op(NFC_OP_RESET, 20'h0, 16'h0);
        st(8'h80, 8'h00, "q left");
        rdchk(20'h00010, 16'hFFFF, "q array");
        $display("test query done");
    endtask : t_query
    task automatic t_otp();
        op(NFC_OP_OTP_ENTER, 20'h0, 16'h0);
        st(8'h20, 8'h20, "otp");
        op(NFC_OP_PROGRAM, 20'h00020, 16'hC3A5);
        repeat (140) @(posedge clk);
        rdchk(20'h00020, 16'hC3A5, "otp word");
        op(NFC_OP_SUSPEND, 20'h0, 16'h0);
        st(8'h08, 8'h08, "otp susp");
        op(NFC_OP_OTP_LOCK, 20'h0, 16'h0);
        st(8'h48, 8'h40, "otp lock");
        op(NFC_OP_PROGRAM, 20'h00021, 16'h0000);
        st(8'h08, 8'h08, "lock ref");
        op(NFC_OP_OTP_EXIT, 20'h0, 16'h0);
        st(8'h20, 8'h00, "otp left");
        rdchk(20'h00020, 16'hFFFF, "main");
        $display("test otp done");
    endtask : t_otp
    task automatic t_guard();
        op(NFC_OP_PROGRAM, 20'h00400, 16'h0F0F);
        repeat (140) @(posedge clk);
        rdchk(20'h00400, 16'hFFFF, "guarded");
        g = 1;
        op(NFC_OP_PROGRAM, 20'h00400, 16'h0F0F);
        cmp({31'h0, boot_guard_boost_pin}, 32'h1, "pin hi");
        repeat (140) @(posedge clk);
        rdchk(20'h00400, 16'h0F0F, "unguarded");
        g = 0;
        op(NFC_OP_PROGRAM, 20'h10009, 16'hBEEF);
        cmp({31'h0, boot_guard_boost_pin}, 32'h0, "pin lo");
        op(NFC_OP_HWRESET, 20'h0, 16'h0);
        st(8'h07, 8'h00, "hw rst");
        repeat (140) @(posedge clk);
        rdchk(20'h10009, 16'hFFFF, "lost");
        $display("test guard done");
    endtask : t_guard
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    initial
    begin
        #1_000_000;
        num_errors++;
        $display("MISMATCH %0t watchdog", $time);
        close_out();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        repeat (20) @(posedge clk);
        t_basic();
        t_suspend();
        t_query();
        t_otp();
        t_guard();
        close_out();
    end
endmodule : nfc_host_tb_top

// >>> verilog/nfc_bus_cycle.sv
// one flash bus cycle
`timescale 1ns/100ps
module nfc_bus_cycle
    import nfc_pkg::*;
#(
    parameter int AW = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // request
    input wire logic start,
    input wire logic is_write,
    input wire logic [AW-1:0] addr,
    input wire logic [15:0] wdata,
    output logic busy,
    output logic done,
    output logic [15:0] rdata,
    // flash pins
    output logic [AW-1:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_sync
);
    initial
    begin
        if (AW < 16)
            $error("bad AW");
    end

    typedef enum logic [1:0] {
        BC_IDLE = 2'b00,
        BC_SETUP = 2'b01,
        BC_STROBE = 2'b10,
        BC_HOLD = 2'b11
    } nfc_bc_state_t;

    localparam int CNT_MAX = (WE_PULSE_CYC > SETUP_CYC) ? WE_PULSE_CYC : SETUP_CYC;
    localparam int CW = $clog2(CNT_MAX + 4);

    nfc_bc_state_t state;
    nfc_bc_state_t next_state;
    logic [CW-1:0] cnt;
    logic wr;
    wire cnt_zero = (cnt == '0);

    always_comb
    begin
        next_state = state;
        case (state)
            BC_IDLE: if (start) next_state = BC_SETUP;
            BC_SETUP: if (cnt_zero) next_state = BC_STROBE;
            BC_STROBE: if (cnt_zero) next_state = BC_HOLD;
            BC_HOLD: if (cnt_zero) next_state = BC_IDLE;
            default: next_state = BC_IDLE;
        endcase
    end

    // read data taken when the hold ends, past the synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= BC_IDLE;
            cnt <= '0;
            wr <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0000;
            fl_addr <= '0;
            fl_ce_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_dq_out <= 16'h0000;
            fl_dq_oe <= 1'b0;
        end
        else if (ce)
        begin
            state <= next_state;
            done <= 1'b0;
            if (state != next_state)
                cnt <= (next_state == BC_STROBE) ? CW'(WE_PULSE_CYC - 1) : CW'(SETUP_CYC - 1);
            else if (!cnt_zero)
                cnt <= cnt - 1'b1;
            case (next_state)
                BC_IDLE:
                begin
                    if (state == BC_HOLD)
                    begin
                        if (!wr)
                            rdata <= fl_dq_sync;
                        done <= 1'b1;
                    end
                    busy <= 1'b0;
                    fl_ce_n <= 1'b1;
                    fl_dq_oe <= 1'b0;
                end
                BC_SETUP:
                begin
                    busy <= 1'b1;
                    if (state == BC_IDLE)
                    begin
                        wr <= is_write;
                        fl_addr <= addr;
                        fl_dq_out <= wdata;
                        fl_dq_oe <= is_write;
                    end
                    fl_ce_n <= 1'b0;
                    fl_oe_n <= 1'b1;
                end
                // write only with ce low, we low, oe high
                BC_STROBE:
                begin
                    fl_we_n <= !wr; // RULE18
                    fl_oe_n <= wr; // RULE18
                end
                BC_HOLD:
                begin
                    fl_we_n <= 1'b1; // RULE24
                    fl_oe_n <= 1'b1;
                end
                default:
                begin
                    fl_ce_n <= 1'b1;
                end
            endcase
        end
    end
endmodule : nfc_bus_cycle

// >>> verilog/nfc_host.sv
// nor flash host controller
// Function
// [RULE1] suspend halts program
// [RULE2] suspended within 10 us
// [RULE3] suspended: reads, autoselect only
// [RULE4] resume continues; address ignored
// [RULE5] read other bank while busy
// [RULE6] no read during chip erase
// [RULE7] guard low locks boot blocks
// [RULE8] guard high: normal protection
// [RULE9] reset between cycles: read mode
// [RULE10] reset ignored while busy
// [RULE11] reset leaves identification mode
// [RULE12] reset after timeout bit
// [RULE13] hardware reset low 500 ns
// [RULE14] hardware reset aborts operation
// [RULE15] read 200 ns after release; the host waits WAKE_CYC after a hardware reset only, not at power-up
// [RULE16] reset held at power-up
// [RULE17] glitches under 5 ns ignored
// [RULE18] write: ce low, we low, oe high
// [RULE19] 98h at 55h enters query
// [RULE20] otp maps 256 words at 0
// [RULE21] otp ends on exit, reset
// [RULE22] locked otp refuses programs
// [RULE23] no suspend with otp lock
// [RULE24] address late fall, data early rise
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps
module nfc_host
    import nfc_pkg::*;
#(
    parameter int AW = 20
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // flash pins
    output logic [AW-1:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_oe_n,
    output logic fl_we_n,
    output logic fl_reset_n,
    output logic boot_guard_boost_pin,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in
);
    initial
    begin
        if (AW < 16 || AW > 32)
            $error("bad AW");
    end

    ////////////////////////////////////////
    // states
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SEQ = 3'b001,
        HS_WAIT = 3'b010,
        HS_HWRST = 3'b011,
        HS_WAKE = 3'b100
    } nfc_hs_state_t;

    ////////////////////////////////////////
    // pin input synchroniser
    logic [15:0] dq_meta;
    logic [15:0] dq_sync;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dq_meta <= 16'h0000;
            dq_sync <= 16'h0000;
        end
        else if (ce)
        begin
            dq_meta <= fl_dq_in;
            dq_sync <= dq_meta;
        end
    end

    ////////////////////////////////////////
    // registers
    nfc_op_t op;
    logic [AW-1:0] op_addr;
    logic [15:0] op_data;
    logic [15:0] last_rdata;
    logic prog_susp;
    logic otp_mode;
    logic otp_locked;
    logic query_mode;
    logic refused;
    logic hw_reset_req;
    nfc_hs_state_t state;
    nfc_hs_state_t next_state;
    logic [2:0] step;
    logic [2:0] nsteps;
    logic [9:0] tmr;

    ////////////////////////////////////////
    // decode of the register port
    wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
    wire wr_addr = reg_wr && (reg_addr == REG_ADDR);
    wire wr_data = reg_wr && (reg_addr == REG_DATA);
    wire go = wr_ctrl && reg_wdata[CTRL_GO_BIT] && (state == HS_IDLE);
    wire nfc_op_t new_op = nfc_op_t'(reg_wdata[CTRL_OP_LSB +: 4]);
    wire otp_target = otp_mode && (op_addr[AW-1:8] == '0);
    // refused orders start no bus cycle; the boot guard pin still follows every control write
    wire op_refused =
        (prog_susp && !(new_op inside {NFC_OP_READ, NFC_OP_AUTOSEL, NFC_OP_RESUME,
                                       NFC_OP_RESET, NFC_OP_HWRESET})) || // RULE3
        (prog_susp && new_op == NFC_OP_OTP_LOCK) || // RULE23
        (!prog_susp && new_op == NFC_OP_RESUME) ||
        (new_op == NFC_OP_SUSPEND && otp_mode) || // RULE23
        (new_op == NFC_OP_PROGRAM && otp_target && otp_locked); // RULE22
    wire [31:0] status_word = {21'h0, query_mode, otp_locked, otp_mode, prog_susp,
                               refused, (state == HS_WAKE), (state == HS_HWRST),
                               (state != HS_IDLE)};
    wire [31:0] rd_mux =
        (reg_addr == REG_CTRL) ? {25'h0, hw_reset_req, boot_guard_boost_pin, 1'b0, 4'(op)} :
        (reg_addr == REG_ADDR) ? 32'(op_addr) :
        (reg_addr == REG_DATA) ? {16'h0, op_data} :
        (reg_addr == REG_STATUS) ? status_word :
        (reg_addr == REG_RDATA) ? {16'h0, last_rdata} : 32'h0000_0000;

    ////////////////////////////////////////
    // command sequence for the current step
    logic [AW-1:0] seq_addr;
    logic [15:0] seq_data;
    logic seq_write;
    always_comb
    begin
        seq_write = 1'b1;
        seq_addr = AW'(CMD_UNLOCK1_ADDR);
        seq_data = CMD_UNLOCK1_DATA;
        nsteps = 3'h1;
        case (op)
            NFC_OP_READ:
            begin
                seq_write = 1'b0;
                seq_addr = op_addr;
            end
            NFC_OP_PROGRAM, NFC_OP_AUTOSEL, NFC_OP_OTP_ENTER, NFC_OP_OTP_EXIT, NFC_OP_OTP_LOCK:
            begin
                nsteps = (op == NFC_OP_PROGRAM || op == NFC_OP_OTP_EXIT) ? 3'h4 : 3'h3;
                if (op == NFC_OP_OTP_LOCK)
                    nsteps = 3'h4;
                case (step)
                    3'h0: seq_data = CMD_UNLOCK1_DATA;
                    3'h1:
                    begin
                        seq_addr = AW'(CMD_UNLOCK2_ADDR);
                        seq_data = CMD_UNLOCK2_DATA;
                    end
                    3'h2:
                    begin
                        seq_addr = (op == NFC_OP_AUTOSEL) ? (op_addr | AW'(CMD_UNLOCK1_ADDR)) :
                                   AW'(CMD_UNLOCK1_ADDR);
                        seq_data = (op == NFC_OP_PROGRAM) ? CMD_PROGRAM :
                                   (op == NFC_OP_AUTOSEL) ? CMD_AUTOSEL :
                                   (op == NFC_OP_OTP_ENTER) ? CMD_OTP_ENTER :
                                   (op == NFC_OP_OTP_EXIT) ? CMD_OTP_EXIT1 : CMD_OTP_LOCK;
                    end
                    default:
                    begin
                        seq_addr = op_addr; // RULE24
                        seq_data = (op == NFC_OP_OTP_EXIT) ? CMD_OTP_EXIT2 : op_data;
                    end
                endcase
            end
            // address ignored here
            NFC_OP_SUSPEND: seq_data = CMD_PSUSPEND; // RULE1
            NFC_OP_RESUME: seq_data = CMD_PRESUME; // RULE4
            NFC_OP_RESET: seq_data = CMD_RESET; // RULE9
            NFC_OP_QUERY:
            begin
                seq_addr = AW'(CMD_QUERY_ADDR);
                seq_data = CMD_QUERY; // RULE19
            end
            default: seq_write = 1'b0;
        endcase
    end

    ////////////////////////////////////////
    // bus cycle engine
    logic bc_start;
    logic bc_busy;
    logic bc_done;
    logic [15:0] bc_rdata;
    nfc_bus_cycle #(
        .AW(AW)
    ) u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .start(bc_start),
        .is_write(seq_write),
        .addr(seq_addr),
        .wdata(seq_data),
        .busy(bc_busy),
        .done(bc_done),
        .rdata(bc_rdata),
        .fl_addr(fl_addr),
        .fl_ce_n(fl_ce_n),
        .fl_oe_n(fl_oe_n),
        .fl_we_n(fl_we_n),
        .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_sync(dq_sync)
    );
    assign bc_start = (state == HS_SEQ) && !bc_busy && !bc_done;
    wire last_step = (step == nsteps - 3'h1);
    wire tmr_zero = (tmr == '0);

    ////////////////////////////////////////
    // state machine
    always_comb
    begin
        next_state = state;
        case (state)
            HS_IDLE:
            begin
                if (go && !op_refused)
                    next_state = (new_op == NFC_OP_HWRESET) ? HS_HWRST : HS_SEQ;
            end
            HS_SEQ: if (bc_done && last_step) next_state = HS_WAIT;
            HS_WAIT: next_state = HS_IDLE;
            HS_HWRST: if (tmr_zero) next_state = HS_WAKE;
            HS_WAKE: if (tmr_zero) next_state = HS_IDLE;
            default: next_state = HS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= HS_IDLE;
            step <= 3'h0;
            tmr <= 10'h000;
        end
        else if (ce)
        begin
            state <= next_state;
            if (state == HS_IDLE)
                step <= 3'h0;
            else if (bc_done)
                step <= step + 3'h1;
            if (next_state == HS_HWRST && state != HS_HWRST)
                tmr <= 10'(RESET_HOLD_CYC - 1); // RULE13
            else if (next_state == HS_WAKE && state != HS_WAKE)
                tmr <= 10'(WAKE_CYC - 1); // RULE15
            else if (!tmr_zero)
                tmr <= tmr - 10'h001;
        end
    end

    // software registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op <= NFC_OP_READ;
            op_addr <= '0;
            op_data <= 16'h0000;
            boot_guard_boost_pin <= 1'b0;
            hw_reset_req <= 1'b0;
            refused <= 1'b0;
            reg_rdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
            if (wr_addr)
                op_addr <= reg_wdata[AW-1:0];
            if (wr_data)
                op_data <= reg_wdata[15:0];
            if (wr_ctrl)
                boot_guard_boost_pin <= reg_wdata[CTRL_BOOT_GUARD_BIT]; // RULE7 RULE8
            if (go)
            begin
                op <= new_op;
                refused <= op_refused;
                hw_reset_req <= (new_op == NFC_OP_HWRESET);
            end
        end
    end

    // mode tracking and pin level reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fl_reset_n <= 1'b0; // RULE16
            prog_susp <= 1'b0;
            otp_mode <= 1'b0;
            otp_locked <= 1'b0;
            query_mode <= 1'b0;
            last_rdata <= 16'h0000;
        end
        else if (ce)
        begin
            fl_reset_n <= (next_state != HS_HWRST); // RULE14 RULE16
            if (state == HS_HWRST)
            begin
                prog_susp <= 1'b0;
                otp_mode <= 1'b0; // RULE21
                query_mode <= 1'b0;
            end
            else if (state == HS_WAIT)
            begin
                case (op)
                    NFC_OP_READ: last_rdata <= query_mode ? {8'h00, bc_rdata[7:0]} : bc_rdata; // RULE19
                    NFC_OP_SUSPEND: prog_susp <= 1'b1; // RULE2
                    NFC_OP_RESUME: prog_susp <= 1'b0;
                    NFC_OP_RESET: query_mode <= 1'b0; // RULE11 RULE12
                    NFC_OP_QUERY: query_mode <= 1'b1;
                    NFC_OP_OTP_ENTER: otp_mode <= 1'b1; // RULE20
                    NFC_OP_OTP_EXIT: otp_mode <= 1'b0; // RULE21
                    NFC_OP_OTP_LOCK: otp_locked <= 1'b1; // RULE22
                    default: query_mode <= query_mode;
                endcase
            end
        end
    end
endmodule : nfc_host

// >>> verilog/nfc_pkg.sv
// constants of the flash host
package nfc_pkg;
    // clock
    localparam int CLK_MHZ = 50;
    // times in ns
    localparam int RESET_HOLD_NS = 500;
    localparam int WAKE_NS = 200;
    localparam int WE_PULSE_NS = 40;
    localparam int SETUP_NS = 20;
    // cycle counts, rounded up
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    // host register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_DATA = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA = 4'h4;
    // control register field positions
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_GO_BIT = 4;
    localparam int CTRL_BOOT_GUARD_BIT = 5;
    localparam int CTRL_HWRST_BIT = 6;
    // reset values
    localparam logic [1:0] CTRL_RESET_VALUE = 2'h0;
    // flash commands
    localparam logic [15:0] CMD_UNLOCK1_ADDR = 16'h0555;
    localparam logic [15:0] CMD_UNLOCK2_ADDR = 16'h02AA;
    localparam logic [15:0] CMD_UNLOCK1_DATA = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2_DATA = 16'h0055;
    localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [15:0] CMD_PSUSPEND = 16'h00B0;
    localparam logic [15:0] CMD_PRESUME = 16'h0030;
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    localparam logic [15:0] CMD_QUERY = 16'h0098;
    localparam logic [15:0] CMD_QUERY_ADDR = 16'h0055;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [15:0] CMD_OTP_ENTER = 16'h0088;
    localparam logic [15:0] CMD_OTP_EXIT1 = 16'h0090;
    localparam logic [15:0] CMD_OTP_EXIT2 = 16'h0000;
    localparam logic [15:0] CMD_OTP_LOCK = 16'h0060;
    localparam logic [7:0] OTP_LAST_WORD = 8'hFF;
    // operations software may order
    typedef enum logic [3:0] {
        NFC_OP_READ = 4'h0,
        NFC_OP_PROGRAM = 4'h1,
        NFC_OP_SUSPEND = 4'h2,
        NFC_OP_RESUME = 4'h3,
        NFC_OP_RESET = 4'h4,
        NFC_OP_QUERY = 4'h5,
        NFC_OP_AUTOSEL = 4'h6,
        NFC_OP_OTP_ENTER = 4'h7,
        NFC_OP_OTP_EXIT = 4'h8,
        NFC_OP_OTP_LOCK = 4'h9,
        NFC_OP_HWRESET = 4'hA
    } nfc_op_t;
endpackage : nfc_pkg
